// [logic/hmc_mode_ctrl.sv]
// Haptic mode control register bank with serial slave and trigger pin
`timescale 1ns/100ps

// What this block does
// RQ1 - Group address answered when enable bit set
// RQ2 - Average of last four periods, zero preload
// RQ3 - Averaging disabled reports latest period only
// RQ4 - Compensation codes give 0,2,4,5 percent
// RQ5 - Trigger function change while busy forces standby
// RQ6 - Pulse setting: pin and launch bit start
// RQ7 - Level setting: pin enables, launch bit ignored
// RQ8 - Interrupt setting: open-drain output, launch bit only
// RQ9 - Mode field selects process, resets to playback
// RQ10 - Mode change while busy forces standby
// RQ11 - Actuator select: 0 rotating, 1 resonant
// RQ12 - Host sets actuator type before calibration
// RQ13 - Loop select zero means closed loop
// RQ14 - Host avoids reserved trigger code three
module hmc_mode_ctrl #(
   // Own bus address, value arbitrary
   parameter logic [6:0] DEV_ADDR = 7'h2a
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Serial register bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Trigger or interrupt pin
   input wire logic trig_in,
   output logic trig_out,
   output logic trig_oe,
   // Playback engine side
   input wire logic process_busy,
   input wire logic irq_pending,
   input wire logic launch_write,
   input wire logic launch_value,
   input wire logic period_valid,
   input wire logic [hmc_pkg::PERIOD_W-1:0] period_meas,
   input wire logic [7:0] drive_level,
   // Configuration and control
   output logic [1:0] op_mode,
   output logic actuator_type,
   output logic loop_select,
   output logic process_start,
   output logic process_cancel,
   output logic process_enable,
   output logic standby_req,
   output logic [7:0] drive_comp
);

   // Serial slave state
   hmc_pkg::hmc_i2c_state_t st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] shift_q, shift_d;
   logic [7:0] tx_q, tx_d;
   logic [7:0] ptr_q, ptr_d;
   logic rw_q, rw_d;
   logic nack_q, nack_d;
   logic sda_drv_q, sda_drv_d;
   logic scl_q, scl_d;
   logic sdap_q, sdap_d;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic scl_rise, scl_fall, start_cond, stop_cond;

   // Register state
   logic [7:0] trig_op_q, trig_op_d;
   logic [7:0] act_drv_q, act_drv_d;
   logic standby_q, standby_d;

   // Control state
   logic trigp_q, trigp_d;
   logic start_q, start_d;
   logic cancel_q, cancel_d;
   logic enable_q, enable_d;
   logic trig_oe_q, trig_oe_d;
   logic [7:0] comp_q, comp_d;
   logic [7:0] pct;
   logic [15:0] prod;
   logic [15:0] quot;
   logic trig_rise, trig_fall;

   logic [hmc_pkg::PERIOD_W-1:0] period_report;

   hmc_pkg::hmc_trig_t trig_func;

   function automatic logic [7:0] read_reg(input logic [7:0] addr,
                                           input logic [7:0] r07,
                                           input logic [7:0] r08,
                                           input logic [9:0] per);
      logic [7:0] v;
      v = 8'h00;
      unique case (addr)
         hmc_pkg::REG_PERIOD_HI: v = {6'h00, per[9:8]};
         hmc_pkg::REG_PERIOD_LO: v = per[7:0];
         hmc_pkg::REG_TRIG_OP_SETUP: v = r07;
         hmc_pkg::REG_ACT_DRIVE_SETUP: v = r08;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   hmc_period_avg u_period_avg (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .sample_valid(period_valid),
      .sample_period(period_meas),
      .avg_disable(trig_op_q[hmc_pkg::AVG_DIS_BIT]),
      .report_q(period_report)
   );

   assign scl_rise = scl_in & ~scl_q;
   assign scl_fall = ~scl_in & scl_q;
   assign start_cond = scl_in & scl_q & sdap_q & ~sda_in;
   assign stop_cond = scl_in & scl_q & ~sdap_q & sda_in;

   // Serial slave next state
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      shift_d = shift_q;
      tx_d = tx_q;
      ptr_d = ptr_q;
      rw_d = rw_q;
      nack_d = nack_q;
      sda_drv_d = sda_drv_q;
      scl_d = scl_in;
      sdap_d = sda_in;
      wr_en = 1'b0;
      wr_addr = ptr_q;
      wr_data = shift_q;
      if (start_cond) begin
         st_d = hmc_pkg::I2_ADDR;
         cnt_d = 4'h0;
         sda_drv_d = 1'b0;
      end else if (stop_cond) begin
         st_d = hmc_pkg::I2_IDLE;
         sda_drv_d = 1'b0;
      end else if (scl_rise) begin
         if (st_q == hmc_pkg::I2_ACK_HOST) begin
            nack_d = sda_in;
         end else if (st_q == hmc_pkg::I2_ADDR || st_q == hmc_pkg::I2_REG ||
                      st_q == hmc_pkg::I2_WDATA || st_q == hmc_pkg::I2_RDATA) begin
            shift_d = {shift_q[6:0], sda_in};
            cnt_d = cnt_q + 4'h1;
         end
      end else if (scl_fall) begin
         unique case (st_q)
            hmc_pkg::I2_ADDR: begin
               if (cnt_q == 4'h8) begin
                  if (shift_q[7:1] == DEV_ADDR ||
                      (trig_op_q[hmc_pkg::GROUP_EN_BIT] &&
                       shift_q[7:1] == hmc_pkg::GROUP_ADDR)) begin // [RQ1]
                     st_d = hmc_pkg::I2_ACK_ADDR;
                     rw_d = shift_q[0];
                     sda_drv_d = 1'b1;
                  end else begin
                     st_d = hmc_pkg::I2_IGNORE;
                  end
               end
            end
            hmc_pkg::I2_ACK_ADDR: begin
               cnt_d = 4'h0;
               if (rw_q) begin
                  st_d = hmc_pkg::I2_RDATA;
                  tx_d = read_reg(ptr_q, trig_op_q, act_drv_q, period_report);
                  sda_drv_d = ~tx_d[7];
               end else begin
                  st_d = hmc_pkg::I2_REG;
                  sda_drv_d = 1'b0;
               end
            end
            hmc_pkg::I2_REG: begin
               if (cnt_q == 4'h8) begin
                  ptr_d = shift_q;
                  st_d = hmc_pkg::I2_ACK_REG;
                  sda_drv_d = 1'b1;
               end
            end
            hmc_pkg::I2_ACK_REG, hmc_pkg::I2_ACK_WDATA: begin
               st_d = hmc_pkg::I2_WDATA;
               cnt_d = 4'h0;
               sda_drv_d = 1'b0;
            end
            hmc_pkg::I2_WDATA: begin
               if (cnt_q == 4'h8) begin
                  wr_en = 1'b1;
                  ptr_d = ptr_q + 8'h01;
                  st_d = hmc_pkg::I2_ACK_WDATA;
                  sda_drv_d = 1'b1;
               end
            end
            hmc_pkg::I2_RDATA: begin
               if (cnt_q == 4'h8) begin
                  st_d = hmc_pkg::I2_ACK_HOST;
                  ptr_d = ptr_q + 8'h01;
                  sda_drv_d = 1'b0;
               end else begin
                  sda_drv_d = ~tx_q[3'(4'h7 - cnt_q)];
               end
            end
            hmc_pkg::I2_ACK_HOST: begin
               cnt_d = 4'h0;
               if (nack_q) begin
                  st_d = hmc_pkg::I2_IGNORE;
                  sda_drv_d = 1'b0;
               end else begin
                  st_d = hmc_pkg::I2_RDATA;
                  tx_d = read_reg(ptr_q, trig_op_q, act_drv_q, period_report);
                  sda_drv_d = ~tx_d[7];
               end
            end
            default: begin
               sda_drv_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= hmc_pkg::I2_IDLE;
         cnt_q <= 4'h0;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         nack_q <= 1'b0;
         sda_drv_q <= 1'b0;
         scl_q <= 1'b1;
         sdap_q <= 1'b1;
      end else if (ce) begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         tx_q <= tx_d;
         ptr_q <= ptr_d;
         rw_q <= rw_d;
         nack_q <= nack_d;
         sda_drv_q <= sda_drv_d;
         scl_q <= scl_d;
         sdap_q <= sdap_d;
      end
   end

   // Register writes and forced standby
   always_comb begin
      trig_op_d = trig_op_q;
      act_drv_d = act_drv_q;
      standby_d = 1'b0;
      if (wr_en && wr_addr == hmc_pkg::REG_TRIG_OP_SETUP) begin
         trig_op_d = wr_data; // [RQ9]
         if (process_busy &&
             wr_data[hmc_pkg::TRIG_LSB +: 2] != trig_op_q[hmc_pkg::TRIG_LSB +: 2]) begin
            standby_d = 1'b1; // [RQ5]
         end
         if (process_busy &&
             wr_data[hmc_pkg::MODE_LSB +: 2] != trig_op_q[hmc_pkg::MODE_LSB +: 2]) begin
            standby_d = 1'b1; // [RQ10]
         end
      end
      if (wr_en && wr_addr == hmc_pkg::REG_ACT_DRIVE_SETUP) begin
         act_drv_d = wr_data; // [RQ11] [RQ13]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trig_op_q <= hmc_pkg::TRIG_OP_SETUP_RESET;
         act_drv_q <= hmc_pkg::ACT_DRIVE_SETUP_RESET;
         standby_q <= 1'b0;
      end else if (ce) begin
         trig_op_q <= trig_op_d;
         act_drv_q <= act_drv_d;
         standby_q <= standby_d;
      end
   end

   assign trig_func = hmc_pkg::hmc_trig_t'(trig_op_q[hmc_pkg::TRIG_LSB +: 2]);
   assign trig_rise = trig_in & ~trigp_q;
   assign trig_fall = ~trig_in & trigp_q;

   // Trigger pin, launch handling and drive compensation
   always_comb begin
      trigp_d = trig_in;
      start_d = 1'b0;
      cancel_d = 1'b0;
      enable_d = 1'b0;
      trig_oe_d = 1'b0;
      unique case (trig_func)
         hmc_pkg::TRIG_LEVEL: begin
            enable_d = trig_in; // [RQ7]
            start_d = trig_rise;
            cancel_d = trig_fall;
         end
         hmc_pkg::TRIG_IRQ: begin
            trig_oe_d = irq_pending; // [RQ8]
            start_d = launch_write & launch_value;
            cancel_d = launch_write & ~launch_value;
         end
         hmc_pkg::TRIG_PULSE, hmc_pkg::TRIG_RSVD: begin
            start_d = trig_rise | (launch_write & launch_value); // [RQ6] [RQ14]
            cancel_d = launch_write & ~launch_value;
         end
      endcase
      if (standby_d) begin
         start_d = 1'b0;
      end
      unique case (trig_op_q[hmc_pkg::COMP_LSB +: 2])
         2'b00: pct = hmc_pkg::COMP_PCT_0; // [RQ4]
         2'b01: pct = hmc_pkg::COMP_PCT_1;
         2'b10: pct = hmc_pkg::COMP_PCT_2;
         2'b11: pct = hmc_pkg::COMP_PCT_3;
      endcase
      prod = 16'(drive_level) * (16'(hmc_pkg::COMP_DENOM) + 16'(pct));
      quot = prod / {8'h00, hmc_pkg::COMP_DENOM};
      comp_d = (quot > 16'h00ff) ? 8'hff : quot[7:0];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trigp_q <= 1'b0;
         start_q <= 1'b0;
         cancel_q <= 1'b0;
         enable_q <= 1'b0;
         trig_oe_q <= 1'b0;
         comp_q <= 8'h00;
      end else if (ce) begin
         trigp_q <= trigp_d;
         start_q <= start_d;
         cancel_q <= cancel_d;
         enable_q <= enable_d;
         trig_oe_q <= trig_oe_d;
         comp_q <= comp_d;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = sda_drv_q;
   assign trig_out = 1'b0;
   assign trig_oe = trig_oe_q;
   assign op_mode = trig_op_q[hmc_pkg::MODE_LSB +: 2];
   assign actuator_type = act_drv_q[hmc_pkg::ACT_TYPE_BIT];
   assign loop_select = act_drv_q[hmc_pkg::LOOP_BIT];
   assign process_start = start_q;
   assign process_cancel = cancel_q;
   assign process_enable = enable_q;
   assign standby_req = standby_q;
   assign drive_comp = comp_q;

endmodule // hmc_mode_ctrl

// [logic/hmc_pkg.sv]
// Constants and types of the haptic mode control register bank
package hmc_pkg;

   // Register indices on the serial bus
   localparam logic [7:0] REG_PERIOD_HI = 8'h05;
   localparam logic [7:0] REG_PERIOD_LO = 8'h06;
   localparam logic [7:0] REG_TRIG_OP_SETUP = 8'h07;
   localparam logic [7:0] REG_ACT_DRIVE_SETUP = 8'h08;

   // Reset values
   localparam logic [7:0] TRIG_OP_SETUP_RESET = 8'h54;
   localparam logic [7:0] ACT_DRIVE_SETUP_RESET = 8'h88;

   // Field positions of trigger_and_operating_setup
   localparam int GROUP_EN_BIT = 7;
   localparam int AVG_DIS_BIT = 6;
   localparam int COMP_LSB = 4;
   localparam int TRIG_LSB = 2;
   localparam int MODE_LSB = 0;

   // Field positions of actuator_drive_setup
   localparam int ACT_TYPE_BIT = 7;
   localparam int LOOP_BIT = 6;

   // Serial bus group address
   localparam logic [6:0] GROUP_ADDR = 7'h58;

   // Drive correction in percent per code
   localparam logic [7:0] COMP_PCT_0 = 8'h00;
   localparam logic [7:0] COMP_PCT_1 = 8'h02;
   localparam logic [7:0] COMP_PCT_2 = 8'h04;
   localparam logic [7:0] COMP_PCT_3 = 8'h05;
   localparam logic [7:0] COMP_DENOM = 8'h64;

   // Period report
   localparam int PERIOD_W = 10;
   localparam int AVG_DEPTH = 4;

   typedef enum logic [1:0] {
      TRIG_PULSE = 2'b00,
      TRIG_LEVEL = 2'b01,
      TRIG_IRQ = 2'b10,
      TRIG_RSVD = 2'b11
   } hmc_trig_t;

   typedef enum logic [1:0] {
      MODE_REAL_TIME_PLAYBACK = 2'b00,
      MODE_SEQUENCER = 2'b01,
      MODE_DIAGNOSTICS = 2'b10,
      MODE_LEVEL_CAL = 2'b11
   } hmc_mode_t;

   typedef enum logic [3:0] {
      I2_IDLE = 4'h0,
      I2_ADDR = 4'h1,
      I2_ACK_ADDR = 4'h2,
      I2_REG = 4'h3,
      I2_ACK_REG = 4'h4,
      I2_WDATA = 4'h5,
      I2_ACK_WDATA = 4'h6,
      I2_RDATA = 4'h7,
      I2_ACK_HOST = 4'h8,
      I2_IGNORE = 4'h9
   } hmc_i2c_state_t;

endpackage

// [logic/hmc_period_avg.sv]
// Resonance period report with optional four-sample averaging
`timescale 1ns/100ps
module hmc_period_avg (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Measured periods
   input wire logic sample_valid,
   input wire logic [hmc_pkg::PERIOD_W-1:0] sample_period,
   input wire logic avg_disable,
   // Report
   output logic [hmc_pkg::PERIOD_W-1:0] report_q
);

   logic [hmc_pkg::PERIOD_W-1:0] stage_q [hmc_pkg::AVG_DEPTH];
   logic [hmc_pkg::PERIOD_W-1:0] stage_d [hmc_pkg::AVG_DEPTH];
   logic [hmc_pkg::PERIOD_W-1:0] report_d;
   logic [hmc_pkg::PERIOD_W+1:0] sum;

   always_comb begin
      stage_d = stage_q;
      if (sample_valid) begin
         stage_d[0] = sample_period;
         for (int i = 1; i < hmc_pkg::AVG_DEPTH; i++) begin
            stage_d[i] = stage_q[i-1];
         end
      end
      sum = '0;
      for (int i = 0; i < hmc_pkg::AVG_DEPTH; i++) begin
         sum = sum + {2'b00, stage_d[i]};
      end
      if (avg_disable) begin
         report_d = stage_d[0]; // [RQ3]
      end else begin
         report_d = sum[hmc_pkg::PERIOD_W+1:2]; // [RQ2]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < hmc_pkg::AVG_DEPTH; i++) begin
            stage_q[i] <= '0; // [RQ2]
         end
         report_q <= '0;
      end else if (ce) begin
         stage_q <= stage_d;
         report_q <= report_d;
      end
   end

endmodule // hmc_period_avg

// [verification/hmc_mode_ctrl_asserts.sv]
// Checker of the haptic mode control block ports
`timescale 1ns/100ps
module hmc_mode_ctrl_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Pins
   input wire logic scl_in,
   input wire logic sda_oe,
   input wire logic trig_in,
   input wire logic trig_out,
   input wire logic trig_oe,
   // Engine side
   input wire logic process_busy,
   input wire logic irq_pending,
   input wire logic [1:0] op_mode,
   input wire logic actuator_type,
   input wire logic loop_select,
   input wire logic process_start,
   input wire logic process_enable,
   input wire logic standby_req
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   pin_out_a: assert property (!trig_out)
      else $error("trigger pin driven high");
   irq_follow_a: assert property (trig_oe && $past(ce) |-> $past(irq_pending))
      else $error("pin pulled without interrupt");
   enable_follow_a: assert property (process_enable && $past(ce) |-> $past(trig_in))
      else $error("enable without pin level");
   standby_cause_a: assert property (standby_req |-> $past(process_busy))
      else $error("standby while idle");
   mode_standby_a: assert property ($past(process_busy) && op_mode != $past(op_mode)
      |-> standby_req)
      else $error("mode change without standby");
   standby_start_a: assert property (standby_req |-> !process_start)
      else $error("start together with standby");
   standby_pulse_a: assert property (standby_req && ce |=> !standby_req)
      else $error("standby longer than one cycle");
   ack_scl_a: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("data pulled while bus clock high");
   reset_state_a: assert property ($past(!rst_n)
      |-> op_mode == 2'h0 && actuator_type && !loop_select)
      else $error("wrong state after reset");
endmodule // hmc_mode_ctrl_asserts
bind hmc_mode_ctrl hmc_mode_ctrl_asserts chk (.clk, .rst_n, .ce, .scl_in, .sda_oe, .trig_in,
   .trig_out, .trig_oe, .process_busy, .irq_pending, .op_mode, .actuator_type, .loop_select,
   .process_start, .process_enable, .standby_req);

// [verification/hmc_host.sv]
// Host model driving the serial register bus
`timescale 1ns/100ps
module hmc_host (
   // Clock
   input wire logic clk,
   // Bus lines
   output logic scl,
   output logic sdl,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sdl = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask
   task automatic bx(input logic b, output logic r);
      sdl = !b;
      w(4);
      scl = 1'b1;
      w(2);
      r = sda;
      w(2);
      scl = 1'b0;
   endtask
   task automatic sta();
      sdl = 1'b0;
      w(4);
      scl = 1'b1;
      w(4);
      sdl = 1'b1;
      w(4);
      scl = 1'b0;
   endtask
   task automatic sto();
      sdl = 1'b1;
      w(4);
      scl = 1'b1;
      w(4);
      sdl = 1'b0;
      w(4);
   endtask
   task automatic byt(input logic [7:0] t, input logic ak, output logic [7:0] r, output logic ra);
      for (int i = 7; i >= 0; i--) begin
         bx(t[i], r[i]);
      end
      bx(ak, ra);
   endtask
   // Write one register, k is the address acknowledge
   task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                     output logic k);
      logic [7:0] x;
      logic y;
      sta();
      byt({a, 1'b0}, 1'b1, x, k);
      byt(p, 1'b1, x, y);
      byt(d, 1'b1, x, y);
      sto();
   endtask
   // Read two bytes from pointer p
   task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [15:0] d);
      logic [7:0] x;
      logic y;
      sta();
      byt({a, 1'b0}, 1'b1, x, y);
      byt(p, 1'b1, x, y);
      sta();
      byt({a, 1'b1}, 1'b1, x, y);
      byt(8'hff, 1'b0, d[15:8], y);
      byt(8'hff, 1'b1, d[7:0], y);
      sto();
   endtask
endmodule // hmc_host

// [verification/hmc_mode_ctrl_bench.sv]
// Self-checking bench of the haptic mode control block
`timescale 1ns/100ps
module hmc_mode_ctrl_bench;
   localparam logic [6:0] A = 7'h2a;
   localparam logic [6:0] G = hmc_pkg::GROUP_ADDR;
   logic clk = 1'b0;
   logic rst_n, ce, tg, scl, sdl;
   logic process_busy, irq_pending, launch_write, launch_value;
   logic period_valid;
   logic [9:0] period_meas;
   logic [7:0] drive_level;
   logic sda_out, sda_oe, trig_out, trig_oe, actuator_type, loop_select;
   logic process_start, process_cancel, process_enable, standby_req;
   logic [1:0] op_mode;
   logic [7:0] drive_comp;
   wire sda_in = !(sdl || sda_oe);
   wire trig_in = tg && !trig_oe;
   int failures = 0, compares = 0, ns = 0, nc = 0, nb = 0;
   always #50 clk = !clk;
   always @(posedge clk) begin
      ns <= ns + int'(process_start);
      nc <= nc + int'(process_cancel);
      nb <= nb + int'(standby_req);
   end
   hmc_mode_ctrl #(.DEV_ADDR(A)) uut (.clk, .rst_n, .ce, .scl_in(scl), .sda_in, .sda_out,
      .sda_oe, .trig_in, .trig_out, .trig_oe, .process_busy, .irq_pending, .launch_write,
      .launch_value, .period_valid, .period_meas, .drive_level, .op_mode, .actuator_type,
      .loop_select, .process_start, .process_cancel, .process_enable, .standby_req, .drive_comp);
   hmc_host h (.clk, .scl, .sdl, .sda(sda_in));
   task automatic ck(input string n, input logic [15:0] e, input logic [15:0] s);
      compares++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic pl(input logic [9:0] v);
      period_meas = v;
      period_valid = 1'b1;
      h.w(1);
      period_valid = 1'b0;
      h.w(1);
   endtask
   task automatic t_rst();
      logic [15:0] d;
      h.rd(A, 8'h07, d);
      ck("regs", 16'h5488, d);
      ck("outs", 16'h0002, {12'h000, op_mode, actuator_type, loop_select});
      ck("pins", 16'h0000, {14'h0000, sda_out, trig_out});
      h.rd(A, 8'h0a, d);
      ck("unmapped", 16'h0000, d);
   endtask
   task automatic t_grp();
      logic k;
      h.wr(G, 8'h08, 8'h48, k);
      ck("group nack", 16'h0001, {15'h0000, k});
      h.wr(A, 8'h07, 8'hd4, k);
      h.wr(G, 8'h08, 8'h48, k);
      ck("group ack", 16'h0000, {15'h0000, k});
      ck("type loop", 16'h0001, {14'h0000, actuator_type, loop_select});
      h.wr(A, 8'h07, 8'h54, k);
   endtask
   task automatic t_per();
      logic k;
      logic [15:0] d;
      h.wr(A, 8'h07, 8'h14, k);
      pl(10'h190);
      h.rd(A, 8'h05, d);
      ck("avg one", 16'h0064, d);
      pl(10'h02c);
      pl(10'h050);
      pl(10'h078);
      pl(10'h0a4);
      h.rd(A, 8'h05, d);
      ck("avg four", 16'h0066, d);
      h.wr(A, 8'h07, 8'h54, k);
      pl(10'h12c);
      h.rd(A, 8'h05, d);
      ck("latest", 16'h012c, d);
   endtask
   task automatic t_comp();
      logic k;
      logic [7:0] e [4] = '{8'hc8, 8'hcc, 8'hd0, 8'hd2};
      for (int c = 0; c < 4; c++) begin
         h.wr(A, 8'h07, {2'b01, 2'(c), 4'h4}, k);
         h.w(3);
         ck("comp", {8'h00, e[c]}, {8'h00, drive_comp});
      end
      ce = 1'b0;
      drive_level = 8'hff;
      h.w(3);
      ck("frozen", 16'h00d2, {8'h00, drive_comp});
      ce = 1'b1;
      h.w(3);
      ck("saturate", 16'h00ff, {8'h00, drive_comp});
      drive_level = 8'hc8;
      h.w(3);
   endtask
   task automatic t_trg();
      logic k;
      int s, c;
      for (int m = 0; m < 3; m++) begin
         h.wr(A, 8'h07, {4'h5, 2'(m), 2'b00}, k);
         s = ns;
         c = nc;
         irq_pending = 1'b1;
         tg = 1'b1;
         h.w(3);
         if (m == 1) ck("enable", 16'h0001, {15'h0000, process_enable});
         if (m == 2) ck("pin", 16'h0000, {15'h0000, trig_in});
         launch_value = 1'b1;
         launch_write = 1'b1;
         h.w(1);
         launch_write = 1'b0;
         h.w(2);
         launch_value = 1'b0;
         launch_write = 1'b1;
         h.w(1);
         launch_write = 1'b0;
         tg = 1'b0;
         irq_pending = 1'b0;
         h.w(3);
         ck("starts", (m == 0) ? 16'h0002 : 16'h0001, 16'(ns - s));
         ck("cancels", 16'h0001, 16'(nc - c));
      end
   endtask
   task automatic t_sby();
      logic k;
      int b;
      b = nb;
      process_busy = 1'b1;
      h.wr(A, 8'h07, 8'h59, k);
      ck("mode", 16'h0001, {14'h0000, op_mode});
      h.wr(A, 8'h07, 8'h59, k);
      h.wr(A, 8'h07, 8'h51, k);
      ck("standby", 16'h0002, 16'(nb - b));
      process_busy = 1'b0;
      h.wr(A, 8'h07, 8'h52, k);
      ck("mode", 16'h0002, {14'h0000, op_mode});
      h.wr(A, 8'h08, 8'h88, k);
      ck("type", 16'h0001, {15'h0000, actuator_type});
      h.wr(A, 8'h07, 8'h53, k);
      ck("mode", 16'h0003, {14'h0000, op_mode});
   endtask
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      tg = 1'b0;
      process_busy = 1'b0;
      irq_pending = 1'b0;
      launch_write = 1'b0;
      launch_value = 1'b0;
      period_valid = 1'b0;
      period_meas = 10'h000;
      drive_level = 8'hc8;
      h.w(8);
      rst_n = 1'b1;
      h.w(2);
      t_rst();
      t_grp();
      t_per();
      t_comp();
      t_trg();
      t_sby();
      end_sim();
   end
   initial begin
      #3000000;
      failures++;
      end_sim();
   end
endmodule // hmc_mode_ctrl_bench
